//--- hdl/cpw_pkg.sv
// Purpose: shared constants and carriers of the complementary pwm output stage
// Assumes: 32-bit register port, one aligned word per register
// Notes:   byte addresses, field layouts and the reset values of the packed registers live here only
package cpw_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_OUTCTL  = 8'h04;
  localparam logic [7:0] OFF_GATE    = 8'h08;
  localparam logic [7:0] OFF_LIMIT3  = 8'h0c;
  localparam logic [7:0] OFF_CYCDATA = 8'h10;
  localparam logic [7:0] OFF_DEAD    = 8'h14;
  localparam logic [7:0] OFF_DUTY_U  = 8'h18;
  localparam logic [7:0] OFF_DUTY_V  = 8'h1c;
  localparam logic [7:0] OFF_DUTY_W  = 8'h20;
  localparam logic [7:0] OFF_INTEN   = 8'h24;
  localparam logic [7:0] OFF_STATUS  = 8'h28;
  localparam logic [7:0] OFF_CNT3    = 8'h2c;
  localparam logic [7:0] OFF_CNT4    = 8'h30;
  localparam logic [7:0] OFF_SUBCNT  = 8'h34;
  localparam logic [7:0] OFF_PINS    = 8'h38;

  typedef struct packed {
    logic syncClear;
    logic cmplEn;
  } cpw_mode_s;

  typedef struct packed {
    logic upperOutputLevelSel;
    logic lowerOutputLevelSel;
    logic carrierSyncToggleEn;
  } cpw_outctl_s;

  // phaseSoftState is {w, v, u}
  typedef struct packed {
    logic       bldcEn;
    logic       upperChop;
    logic       lowerChop;
    logic       feedbackSourceSel;
    logic [2:0] phaseSoftState;
  } cpw_gate_s;

  typedef struct packed {
    logic adcTriggerEnable;
    logic underflowEn;
    logic overflowEn;
    logic matchEn;
  } cpw_inten_s;

  typedef struct packed {
    logic underflow;
    logic overflow;
    logic match;
  } cpw_flags_s;

  localparam cpw_mode_s   RST_MODE   = '{syncClear: 1'b0, cmplEn: 1'b0};
  localparam cpw_outctl_s RST_OUTCTL = '{default: 1'b0};
  localparam cpw_gate_s   RST_GATE   = '{bldcEn: 1'b0, upperChop: 1'b0, lowerChop: 1'b0,
                                         feedbackSourceSel: 1'b0, phaseSoftState: 3'h0};
  localparam cpw_inten_s  RST_INTEN  = '{default: 1'b0};
  localparam cpw_flags_s  RST_FLAGS  = '{default: 1'b0};
  localparam logic [1:0]  IRQ_NONE   = 2'h0;
  localparam logic [1:0]  IRQ_MATCH  = 2'h1;
  localparam logic [1:0]  IRQ_OVF    = 2'h2;
  localparam logic [1:0]  IRQ_UDF    = 2'h3;
  localparam logic        TOGGLE_INIT = 1'b1;

endpackage

//--- hdl/cpw_complementary_pwm.sv
// Purpose: three-phase complementary pwm output stage with motor commutation
// Assumes: all inputs except shutdownIn and clkStopIn synchronous to clk; register port answers reads one cycle later
// Notes:   shutdown inputs set the output enables without waiting for a clock edge
`timescale 1ns/1ps
`default_nettype none
module cpw_complementary_pwm #(
  parameter int unsigned W = 16
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [cpw_pkg::ADDR_W-1:0]  addr,
  input  wire logic [cpw_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output var  logic [cpw_pkg::DATA_W-1:0]  rdata,
  input  wire logic                        accessEn,
  input  wire logic                        syncClearIn,
  input  wire logic                        otherMatchIn,
  input  wire logic [2:0]                  hallIn,
  input  wire logic [3:0]                  shutdownIn,
  input  wire logic                        clkStopIn,
  output var  logic [5:0]                  pwmPin,
  output var  logic [5:0]                  pwmOeN,
  output var  logic                        ch3aPin,
  output var  logic                        adcStart,
  output var  logic [2:0]                  irq,
  output var  logic [1:0]                  irqCode
);

  if (W < 4 || W > 32)
  begin : g_width_check
    $error("counter width must lie between 4 and 32");
  end

  cpw_pkg::cpw_mode_s   mode;
  cpw_pkg::cpw_outctl_s outCtl;
  cpw_pkg::cpw_gate_s   gate;
  cpw_pkg::cpw_inten_s  intEn;
  cpw_pkg::cpw_flags_s  flags;
  logic [W-1:0]         limit3;
  logic [W-1:0]         cycData;
  logic [W-1:0]         deadTime;
  logic [W-1:0]         dutyBuf [3];
  logic [W-1:0]         duty    [3];
  logic [W-1:0]         cnt3;
  logic [W-1:0]         cnt4;
  logic [W-1:0]         subCnt;
  logic                 up;
  logic                 initDone;
  logic [2:0]           posOn;
  logic [2:0]           negOn;
  logic [2:0]           armP;
  logic [2:0]           armN;
  logic [2:0]           rawOffP;
  logic [2:0]           rawOnP;
  logic [2:0]           rawOffN;
  logic [2:0]           rawOnN;
  logic [2:0]           pOff;
  logic [2:0]           pOn;
  logic [2:0]           nOff;
  logic [2:0]           nOn;
  logic [2:0]           hallPrev;
  logic [2:0]           commState;
  logic [5:0]           next_pin;
  logic [31:0]          next_rdata;
  logic                 wrP;
  logic                 syncHit;
  logic                 crestHit;
  logic                 troughHit;
  logic                 shutAny;
  logic [2:0]           flagSet;
  logic [2:0]           flagClr;

  assign wrP       = wr && accessEn;
  assign syncHit   = mode.cmplEn && mode.syncClear && syncClearIn;
  assign crestHit  = mode.cmplEn && (cnt3 == limit3);
  assign troughHit = mode.cmplEn && !up && (cnt4 == '0);
  assign shutAny   = (|shutdownIn) || clkStopIn;

  // register writes; duty buffers stay writable even when access is locked
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode     <= cpw_pkg::RST_MODE;
      outCtl   <= cpw_pkg::RST_OUTCTL;
      gate     <= cpw_pkg::RST_GATE;
      intEn    <= cpw_pkg::RST_INTEN;
      limit3   <= '0;
      cycData  <= '0;
      deadTime <= '0;
      for (int i = 0; i < 3; i++) dutyBuf[i] <= '0;
    end
    else
    begin
      if (wrP && addr == cpw_pkg::OFF_MODE) mode <= wdata[1:0];
      else if (wrP && addr == cpw_pkg::OFF_OUTCTL) outCtl <= wdata[2:0];
      else if (wrP && addr == cpw_pkg::OFF_GATE) gate <= wdata[6:0];
      else if (wrP && addr == cpw_pkg::OFF_INTEN) intEn <= wdata[3:0];
      else if (wrP && addr == cpw_pkg::OFF_LIMIT3) limit3 <= wdata[W-1:0];
      else if (wrP && addr == cpw_pkg::OFF_CYCDATA) cycData <= wdata[W-1:0];
      else if (wrP && addr == cpw_pkg::OFF_DEAD) deadTime <= wdata[W-1:0];
      else if (wr && addr == cpw_pkg::OFF_DUTY_U) dutyBuf[0] <= wdata[W-1:0];
      else if (wr && addr == cpw_pkg::OFF_DUTY_V) dutyBuf[1] <= wdata[W-1:0];
      else if (wr && addr == cpw_pkg::OFF_DUTY_W) dutyBuf[2] <= wdata[W-1:0];
    end
  end

  // up/down carrier; channel 3 runs dead time ahead of channel 4
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt3 <= '0;
      cnt4 <= '0;
      up   <= 1'b1;
    end
    else if (!mode.cmplEn || syncHit)
    begin
      cnt3 <= deadTime;
      cnt4 <= '0;
      up   <= 1'b1;
    end
    else if (up && cnt3 >= limit3)
    begin
      up   <= 1'b0;
      cnt3 <= cnt3 - 1'b1;
      cnt4 <= cnt4 - 1'b1;
    end
    else if (!up && cnt4 == '0)
    begin
      up   <= 1'b1;
      cnt3 <= cnt3 + 1'b1;
      cnt4 <= cnt4 + 1'b1;
    end
    else if (up)
    begin
      cnt3 <= cnt3 + 1'b1;
      cnt4 <= cnt4 + 1'b1;
    end
    else
    begin
      cnt3 <= cnt3 - 1'b1;
      cnt4 <= cnt4 - 1'b1;
    end
  end

  // subcounter only runs inside the dead-time zones at crest and trough
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) subCnt <= '0;
    else if (!mode.cmplEn || syncHit) subCnt <= '0;
    else if (cnt3 > cycData || cnt4 < deadTime) subCnt <= subCnt + 1'b1;
    else subCnt <= '0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) initDone <= 1'b0;
    else if (!mode.cmplEn) initDone <= 1'b0;
    else if (cnt4 > deadTime) initDone <= 1'b1;
  end

  // new duty takes effect at the trough so a half cycle never sees two values
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 3; i++) duty[i] <= '0;
    end
    else if (!mode.cmplEn || troughHit)
    begin
      for (int i = 0; i < 3; i++) duty[i] <= dutyBuf[i];
    end
  end

  // positive-phase timings from the leading counter, negative-phase timings from the delayed one
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      rawOffP[i] = up && (cnt3 == duty[i]);
      rawOnN[i]  = up && (cnt4 == duty[i]);
      rawOffN[i] = !up && (cnt4 == duty[i]);
      rawOnP[i]  = !up && (cnt3 == duty[i]);
      pOff[i]    = rawOffP[i] && !rawOnP[i];
      nOff[i]    = rawOffN[i] && !rawOnN[i];
      pOn[i]     = rawOnP[i] && !rawOffP[i] && armP[i] && !nOff[i];
      nOn[i]     = rawOnN[i] && !rawOffN[i] && armN[i] && !pOff[i];
    end
  end

  // with a duty between zero and the cycle limit, a phase may only turn on after the opposite phase has turned off
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      posOn <= '0;
      negOn <= '0;
      armP  <= '0;
      armN  <= '0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (!mode.cmplEn)
        begin
          posOn[i] <= 1'b0;
          negOn[i] <= 1'b0;
          armP[i]  <= 1'b0;
          armN[i]  <= 1'b0;
        end
        else if (duty[i] == '0)
        begin
          posOn[i] <= 1'b1;
          negOn[i] <= 1'b0;
          armP[i]  <= 1'b0;
          armN[i]  <= 1'b0;
        end
        else if (duty[i] >= limit3)
        begin
          posOn[i] <= 1'b0;
          negOn[i] <= 1'b1;
          armP[i]  <= 1'b0;
          armN[i]  <= 1'b0;
        end
        else
        begin
          posOn[i] <= pOff[i] ? 1'b0 : (pOn[i] ? 1'b1 : posOn[i]);
          negOn[i] <= nOff[i] ? 1'b0 : (nOn[i] ? 1'b1 : negOn[i]);
          armP[i]  <= nOff[i] ? 1'b1 : ((pOn[i] || pOff[i]) ? 1'b0 : armP[i]);
          armN[i]  <= pOff[i] ? 1'b1 : ((nOn[i] || nOff[i]) ? 1'b0 : armN[i]);
        end
      end
    end
  end

  // commutation state: hall edges or software bits pick the conducting pair
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hallPrev  <= '0;
      commState <= '0;
    end
    else
    begin
      hallPrev <= hallIn;
      if (gate.feedbackSourceSel) commState <= gate.phaseSoftState;
      else if (hallIn != hallPrev) commState <= hallIn;
    end
  end

  always_comb
  begin
    logic upSel;
    logic loSel;
    logic upOn;
    logic loOn;
    upSel = 1'b0;
    loSel = 1'b0;
    upOn  = 1'b0;
    loOn  = 1'b0;
    next_pin = '0;
    for (int i = 0; i < 3; i++)
    begin
      upSel = commState[i] && !commState[(i + 1) % 3];
      loSel = !commState[i] && commState[(i + 1) % 3];
      if (gate.bldcEn)
      begin
        upOn = upSel && (gate.upperChop ? (posOn[i] && initDone) : 1'b1);
        loOn = loSel && (gate.lowerChop ? (negOn[i] && initDone) : 1'b1);
      end
      else
      begin
        upOn = posOn[i] && initDone;
        loOn = negOn[i] && initDone;
      end
      next_pin[i]     = upOn ? outCtl.upperOutputLevelSel : !outCtl.upperOutputLevelSel;
      next_pin[i + 3] = loOn ? outCtl.lowerOutputLevelSel : !outCtl.lowerOutputLevelSel;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) pwmPin <= '0;
    else pwmPin <= next_pin;
  end

  // asynchronous set keeps the bridge safe even if the clock has died; it also beats reset
  always_ff @(posedge clk or negedge rstn or posedge shutAny)
  begin
    if (shutAny) pwmOeN <= '1;
    else if (!rstn) pwmOeN <= '0;
    else pwmOeN <= '0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) ch3aPin <= cpw_pkg::TOGGLE_INIT;
    else if (!mode.cmplEn || !outCtl.carrierSyncToggleEn) ch3aPin <= cpw_pkg::TOGGLE_INIT;
    else if (crestHit || troughHit) ch3aPin <= !ch3aPin;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) adcStart <= 1'b0;
    else adcStart <= intEn.adcTriggerEnable && (crestHit || otherMatchIn);
  end

  assign flagSet = {troughHit, up && crestHit && (cnt4 == cycData), crestHit};
  assign flagClr = (wr && addr == cpw_pkg::OFF_STATUS) ? ~wdata[2:0] : 3'h0;

  // an event in the clearing cycle survives
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) flags <= cpw_pkg::RST_FLAGS;
    else flags <= (flags & ~flagClr) | flagSet;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq     <= '0;
      irqCode <= cpw_pkg::IRQ_NONE;
    end
    else
    begin
      irq <= {flags.underflow && intEn.underflowEn, flags.overflow && intEn.overflowEn,
              flags.match && intEn.matchEn};
      if (flags.match && intEn.matchEn) irqCode <= cpw_pkg::IRQ_MATCH;
      else if (flags.overflow && intEn.overflowEn) irqCode <= cpw_pkg::IRQ_OVF;
      else if (flags.underflow && intEn.underflowEn) irqCode <= cpw_pkg::IRQ_UDF;
      else irqCode <= cpw_pkg::IRQ_NONE;
    end
  end

  // locked registers read as zero
  always_comb
  begin
    next_rdata = '0;
    if (addr == cpw_pkg::OFF_MODE && accessEn) next_rdata[1:0] = mode;
    else if (addr == cpw_pkg::OFF_OUTCTL && accessEn) next_rdata[2:0] = outCtl;
    else if (addr == cpw_pkg::OFF_GATE && accessEn) next_rdata[6:0] = gate;
    else if (addr == cpw_pkg::OFF_INTEN && accessEn) next_rdata[3:0] = intEn;
    else if (addr == cpw_pkg::OFF_LIMIT3 && accessEn) next_rdata[W-1:0] = limit3;
    else if (addr == cpw_pkg::OFF_CYCDATA && accessEn) next_rdata[W-1:0] = cycData;
    else if (addr == cpw_pkg::OFF_DEAD && accessEn) next_rdata[W-1:0] = deadTime;
    else if (addr == cpw_pkg::OFF_CNT3 && accessEn) next_rdata[W-1:0] = cnt3;
    else if (addr == cpw_pkg::OFF_CNT4 && accessEn) next_rdata[W-1:0] = cnt4;
    else if (addr == cpw_pkg::OFF_DUTY_U) next_rdata[W-1:0] = dutyBuf[0];
    else if (addr == cpw_pkg::OFF_DUTY_V) next_rdata[W-1:0] = dutyBuf[1];
    else if (addr == cpw_pkg::OFF_DUTY_W) next_rdata[W-1:0] = dutyBuf[2];
    else if (addr == cpw_pkg::OFF_STATUS) next_rdata[2:0] = flags;
    else if (addr == cpw_pkg::OFF_SUBCNT) next_rdata[W-1:0] = subCnt;
    else if (addr == cpw_pkg::OFF_PINS) next_rdata[9:0] = {commState, ch3aPin, pwmPin};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) rdata <= '0;
    else if (rd) rdata <= next_rdata;
    else rdata <= '0;
  end

  sequence seqToggleLive;
    mode.cmplEn && outCtl.carrierSyncToggleEn;
  endsequence

  sequence seqCrestKept;
    seqToggleLive and crestHit ##1 seqToggleLive;
  endsequence

  chk_phase_no_overlap: assert property (@(posedge clk) disable iff (!rstn)
    (posOn & negOn) == 3'h0) else $error("positive and negative phase on together");
  // a duty at the cycle limit makes the off and on matches meet at the crest
  chk_coincide_hold: assert property (@(posedge clk) disable iff (!rstn)
    (mode.cmplEn && crestHit && duty[1] == limit3)
    |=> posOn[1] == $past(posOn[1]) && negOn[1] == $past(negOn[1]))
    else $error("coincident matches changed phase");
  chk_full_duty: assert property (@(posedge clk) disable iff (!rstn)
    (mode.cmplEn && duty[0] == '0) |=> posOn[0] && !negOn[0])
    else $error("zero duty did not hold positive on");
  chk_zero_duty: assert property (@(posedge clk) disable iff (!rstn)
    (mode.cmplEn && duty[1] == limit3) |=> !posOn[1]) else $error("limit duty left positive on");
  chk_toggle_flip: assert property (@(posedge clk) disable iff (!rstn)
    seqCrestKept |-> ch3aPin != $past(ch3aPin)) else $error("toggle missed crest match");
  chk_toggle_start: assert property (@(posedge clk) disable iff (!rstn)
    !(mode.cmplEn && outCtl.carrierSyncToggleEn) |=> ch3aPin) else $error("toggle not at one");
  chk_adc_gate: assert property (@(posedge clk) disable iff (!rstn)
    adcStart |-> $past(intEn.adcTriggerEnable) && $past(crestHit || otherMatchIn))
    else $error("adc start without enable or cause");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (flags.match && !(wr && addr == cpw_pkg::OFF_STATUS && !wdata[0])) |=> flags.match)
    else $error("match flag dropped without clear");
  chk_irq_follow: assert property (@(posedge clk) disable iff (!rstn)
    (flags.overflow && intEn.overflowEn) |=> irq[1]) else $error("overflow request missing");
  chk_shutdown_oe: assert property (@(posedge clk) disable iff (!rstn)
    shutAny |=> pwmOeN == 6'h3f) else $error("outputs driven during shutdown");
  chk_lock_limit: assert property (@(posedge clk) disable iff (!rstn)
    (wr && !accessEn && addr == cpw_pkg::OFF_LIMIT3) |=> $stable(limit3))
    else $error("locked register changed");
  chk_sync_clear: assert property (@(posedge clk) disable iff (!rstn)
    syncHit |=> cnt4 == '0 && subCnt == '0 && cnt3 == $past(deadTime))
    else $error("sync clear left counters running");

endmodule
`default_nettype wire

//--- bench/cpw_drive_model.sv
// Purpose: gate driver and hall sensor stand-in for the pwm output stage
// Assumes: pins are upper u,v,w then lower u,v,w, both level selects active high
// Notes:   a released pad shows the inverse of its last level, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module cpw_drive_model (
  input  wire logic       clk,
  input  wire logic [5:0] pwmPin,
  input  wire logic [5:0] pwmOeN,
  input  wire logic       hallStep,
  input  wire logic       watch,
  output var  logic [2:0] hallIn,
  output var  logic [5:0] pad,
  output var  int         shootThrough
);
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int         idx = 0;
  int         hits = 0;
  logic [5:0] padQ = 6'h00;
  logic [5:0] lastDrv = 6'h00;

  assign hallIn = seq[idx];
  assign pad = padQ;
  assign shootThrough = hits;

  always @(posedge clk)
  begin
    if (hallStep)
      idx <= (idx + 1) % 6;
    for (int i = 0; i < 6; i++)
    begin
      padQ[i] <= pwmOeN[i] ? ~lastDrv[i] : pwmPin[i];
      if (!pwmOeN[i])
        lastDrv[i] <= pwmPin[i];
    end
    // both switches of one leg on together would short the dc bus
    for (int i = 0; i < 3; i++)
      if (watch && !pwmOeN[i] && !pwmOeN[i+3] && pwmPin[i] && pwmPin[i+3])
        hits <= hits + 1;
  end
endmodule
`default_nettype wire

//--- bench/cpw_complementary_pwm_tb.sv
// Purpose: self-checking bench of the complementary pwm output stage
// Assumes: reads answer one cycle later; level selects set active high for waveforms
// Notes:   waveforms are judged over whole carrier periods, not at exact edges
`timescale 1ns/1ps
`default_nettype none
`define CPW_CHECK(got, exp) \
  begin \
    nChecks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); \
    end \
  end
module cpw_complementary_pwm_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        accessEn = 1'b1;
  logic        syncClearIn = 1'b0;
  logic        otherMatchIn = 1'b0;
  logic [2:0]  hallIn;
  logic [3:0]  shutdownIn = 4'h0;
  logic        clkStopIn = 1'b0;
  logic [5:0]  pwmPin;
  logic [5:0]  pwmOeN;
  logic        ch3aPin;
  logic        adcStart;
  logic [2:0]  irq;
  logic [1:0]  irqCode;
  logic        hallStep = 1'b0;
  logic        watch = 1'b0;
  int          shootThrough;
  int          failures = 0;
  int          nChecks = 0;
  int          cycles = 0;
  logic [31:0] rv;

  always #10 clk = ~clk;

  cpw_complementary_pwm #(.W(16)) dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .accessEn(accessEn), .syncClearIn(syncClearIn),
    .otherMatchIn(otherMatchIn), .hallIn(hallIn), .shutdownIn(shutdownIn),
    .clkStopIn(clkStopIn), .pwmPin(pwmPin), .pwmOeN(pwmOeN), .ch3aPin(ch3aPin),
    .adcStart(adcStart), .irq(irq), .irqCode(irqCode));

  cpw_drive_model model (.clk(clk), .pwmPin(pwmPin), .pwmOeN(pwmOeN), .hallStep(hallStep),
    .watch(watch), .hallIn(hallIn), .pad(), .shootThrough(shootThrough));

  task automatic final_report;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic test_reset;
    repeat (4) @(posedge clk);
    `CPW_CHECK(ch3aPin, 1'b1)
    `CPW_CHECK(pwmOeN, 6'h00)
    rstn <= 1'b1;
    @(posedge clk);
    #1 `CPW_CHECK(pwmPin, 6'h3f)
  endtask

  task automatic test_access;
    reg_wr(cpw_pkg::OFF_LIMIT3, 32'd10);
    @(posedge clk);
    accessEn <= 1'b0;
    reg_wr(cpw_pkg::OFF_LIMIT3, 32'd5);
    reg_wr(cpw_pkg::OFF_DUTY_U, 32'd7);
    reg_rd(cpw_pkg::OFF_LIMIT3, rv);
    `CPW_CHECK(rv, 32'h0)
    reg_rd(cpw_pkg::OFF_DUTY_U, rv);
    `CPW_CHECK(rv, 32'd7)
    @(posedge clk);
    accessEn <= 1'b1;
    reg_rd(cpw_pkg::OFF_LIMIT3, rv);
    `CPW_CHECK(rv, 32'd10)
    reg_rd(8'h3c, rv);
    `CPW_CHECK(rv, 32'h0)
  endtask

  task automatic test_shutdown;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      if (i < 4)
        shutdownIn <= 4'h1 << i;
      else
        clkStopIn <= 1'b1;
      // checked before the next edge, so only an asynchronous path passes
      #1 `CPW_CHECK(pwmOeN, 6'h3f)
      @(posedge clk);
      shutdownIn <= 4'h0;
      clkStopIn  <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CPW_CHECK(pwmOeN, 6'h00)
    end
  endtask

  task automatic test_adc;
    for (int en = 0; en < 2; en++)
    begin
      reg_wr(cpw_pkg::OFF_INTEN, 32'(en << 3));
      otherMatchIn <= 1'b1;
      @(posedge clk);
      otherMatchIn <= 1'b0;
      #1 `CPW_CHECK(adcStart, 1'(en))
      @(posedge clk);
      #1 `CPW_CHECK(adcStart, 1'b0)
    end
  endtask

  task automatic test_carrier;
    logic uOn = 1'b1;
    logic uLo = 1'b0;
    logic vHi = 1'b0;
    logic wHi = 1'b0;
    logic wLo = 1'b0;
    logic irqSeen = 1'b0;
    logic prev;
    int   toggles = 0;
    int   adcs = 0;
    reg_wr(cpw_pkg::OFF_CYCDATA, 32'd8);
    reg_wr(cpw_pkg::OFF_DEAD, 32'd2);
    reg_wr(cpw_pkg::OFF_DUTY_U, 32'd0);
    reg_wr(cpw_pkg::OFF_DUTY_V, 32'd10);
    reg_wr(cpw_pkg::OFF_DUTY_W, 32'd5);
    reg_wr(cpw_pkg::OFF_OUTCTL, 32'h7);
    reg_wr(cpw_pkg::OFF_INTEN, 32'h9);
    reg_wr(cpw_pkg::OFF_MODE, 32'h3);
    #1 `CPW_CHECK(ch3aPin, 1'b1)
    repeat (20) @(posedge clk);
    watch <= 1'b1;
    prev = ch3aPin;
    repeat (48)
    begin
      @(posedge clk);
      #1;
      uOn &= pwmPin[0];
      uLo |= pwmPin[3];
      vHi |= pwmPin[1];
      wHi |= pwmPin[2];
      wLo |= ~pwmPin[2];
      irqSeen |= irq[0];
      toggles += int'(ch3aPin != prev);
      adcs += int'(adcStart);
      prev = ch3aPin;
    end
    watch <= 1'b0;
    `CPW_CHECK({uOn, uLo}, 2'b10)
    `CPW_CHECK(vHi, 1'b0)
    `CPW_CHECK({wHi, wLo}, 2'b11)
    `CPW_CHECK(shootThrough, 0)
    `CPW_CHECK(toggles >= 4, 1'b1)
    `CPW_CHECK(adcs >= 2, 1'b1)
    `CPW_CHECK(irqSeen, 1'b1)
    `CPW_CHECK(irqCode, cpw_pkg::IRQ_MATCH)
    @(posedge clk);
    syncClearIn <= 1'b1;
    @(posedge clk);
    syncClearIn <= 1'b0;
    reg_rd(cpw_pkg::OFF_CNT4, rv);
    `CPW_CHECK(rv < 32'd3, 1'b1)
    reg_wr(cpw_pkg::OFF_MODE, 32'h0);
    reg_rd(cpw_pkg::OFF_STATUS, rv);
    `CPW_CHECK(rv[2:0], 3'h7)
    `CPW_CHECK(irq, 3'h1)
    reg_wr(cpw_pkg::OFF_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    #1 `CPW_CHECK(irq, 3'h0)
  endtask

  task automatic test_hall;
    reg_wr(cpw_pkg::OFF_GATE, 32'h40);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      hallStep <= 1'b1;
      @(posedge clk);
      hallStep <= 1'b0;
      repeat (2) @(posedge clk);
      reg_rd(cpw_pkg::OFF_PINS, rv);
      `CPW_CHECK(rv[9:7], hallIn)
    end
    reg_wr(cpw_pkg::OFF_GATE, 32'h4d);
    repeat (2) @(posedge clk);
    reg_rd(cpw_pkg::OFF_PINS, rv);
    `CPW_CHECK(rv[9:7], 3'h5)
    `CPW_CHECK(rv[5:0], 6'h11)
    reg_wr(cpw_pkg::OFF_GATE, 32'h6d);
    repeat (2) @(posedge clk);
    reg_rd(cpw_pkg::OFF_PINS, rv);
    `CPW_CHECK(rv[5:0], 6'h10)
  endtask

  // the sequence needs well under a thousand cycles; the ceiling only cuts hangs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      final_report();
    end
  end

  initial
  begin
    test_reset();
    test_access();
    test_shutdown();
    test_adc();
    test_carrier();
    test_hall();
    final_report();
  end
endmodule
`default_nettype wire
